// ---- scq_pkg.sv ----
// Package for the scan-cycle sample queue
package scq_pkg;
  localparam int DATA_W = 16;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int TIME_W = 48;
  localparam int CTW_W = 16;
  // Control word bit positions
  localparam int CTW_MODE_HI = 11;
  localparam int CTW_MODE_LO = 8;
  localparam int CTW_NOTIME = 9;
  localparam int CTW_EVERYTIME = 10;
  // Status word bit positions
  localparam int ST_EN = 0;
  localparam int ST_LOAD = 1;
  localparam int ST_UNLOAD = 2;
  localparam int ST_CLEAR = 3;
  localparam int ST_ENO = 4;
  localparam int ST_EMPTY = 5;
  localparam int ST_TRIG = 6;
  localparam int ST_FULL = 7;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [PTR_W-1:0] PTR_LAST = 4'hF;
  typedef enum logic [1:0] {
    SCQ_STANDARD = 2'h0,
    SCQ_WINDOW = 2'h1,
    SCQ_CIRCULAR = 2'h3
  } scq_mode_t;
  typedef enum logic [1:0] {
    SCQ_LAST_TIME = 2'h0,
    SCQ_NO_TIME = 2'h1,
    SCQ_EACH_TIME = 2'h3
  } scq_log_t;
  typedef enum logic [1:0] {
    SCQ_RUN = 2'h0,
    SCQ_WIPE = 2'h1
  } scq_state_t;
  // One scan's worth of block inputs
  typedef struct packed {
    logic en;
    logic load;
    logic unload;
    logic clear;
  } scq_ctrl_t;
  // Block flag outputs
  typedef struct packed {
    logic enable_passthrough_out;
    logic empty;
    logic trig;
    logic full;
  } scq_flags_t;
endpackage

// ---- scq_sync.sv ----
// Two-flop synchroniser with rising-edge detect
`timescale 1ns/1ps
`default_nettype none
module scq_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Signal
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);
  logic meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end
  assign level_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
endmodule
`default_nettype wire

// ---- scq_queue.sv ----
// Scan-cycle sample queue with modes, time logging and host read port
//
// Functional notes
// RULE1: Each instance owns its private sample storage array, retained across scans.
// RULE2: Queue depth is fixed at build time by a size constant.
// RULE3: Host reads samples and time-stamps directly by relative address.
// RULE4: Standard mode refuses samples while full until an entry is removed.
// RULE5: Moving window drops the oldest entry, then stores the new sample.
// RULE6: Circular mode overwrites the oldest slot; other entries stay put.
// RULE7: Three time logging options are selectable.
// RULE8: Last-time option keeps only the newest sample's time-stamp.
// RULE9: No-time option records no sampling time.
// RULE10: Value-and-time option stores every sample's own time-stamp.
// RULE11: Rising load starts capture of the data input.
// RULE12: While loading, one sample per scan and the write pointer advances.
// RULE13: Rising unload removes the oldest entry.
// RULE14: Clear erases the whole storage region.
// RULE15: Mode from control bits 11 and 8: 00 standard, 01 window, 1x circular.
// RULE16: Bit 9 selects no time, bit 10 every time, neither last time.
// RULE17: Empty exactly when count is zero; full exactly when all slots used.
// RULE18: Trigger goes true when stored count reaches the trigger count.
// RULE19: With enable low nothing is captured or removed; enable out is low. Clear still empties and wipes the queue with enable low.
// RULE20: Unload on an empty queue changes nothing; empty stays true.
`timescale 1ns/1ps
`default_nettype none
module scq_queue (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Scan strobe from the controller
  input wire logic scan,
  // Block control pins
  input wire scq_pkg::scq_ctrl_t ctrl_pins,
  input wire logic [scq_pkg::DATA_W-1:0] data_in,
  input wire logic [scq_pkg::TIME_W-1:0] time_now,
  // Configuration
  input wire logic [scq_pkg::CTW_W-1:0] queue_control_word,
  input wire logic [scq_pkg::CNT_W-1:0] trigger_count,
  // Host read port
  input wire logic [scq_pkg::PTR_W-1:0] rd_addr,
  input wire logic rd_stb,
  output logic [scq_pkg::DATA_W-1:0] rd_data,
  output logic [scq_pkg::TIME_W-1:0] rd_time,
  output logic [scq_pkg::TIME_W-1:0] last_time,
  // Block outputs
  output scq_pkg::scq_flags_t flags,
  output logic [scq_pkg::PTR_W-1:0] queue_base_pointer,
  output logic [scq_pkg::CNT_W-1:0] fill_count,
  output logic [scq_pkg::CTW_W-1:0] status_word
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic en_lvl, load_lvl, unload_lvl, clear_lvl;
  logic load_rise, unload_rise;
  scq_sync u_en (.clk(clk), .rst(rst), .ce(ce), .async_in(ctrl_pins.en), .level_out(en_lvl), .rise_out());
  scq_sync u_load (.clk(clk), .rst(rst), .ce(ce), .async_in(ctrl_pins.load), .level_out(load_lvl),
    .rise_out(load_rise));
  scq_sync u_unload (.clk(clk), .rst(rst), .ce(ce), .async_in(ctrl_pins.unload), .level_out(unload_lvl),
    .rise_out(unload_rise));
  scq_sync u_clear (.clk(clk), .rst(rst), .ce(ce), .async_in(ctrl_pins.clear), .level_out(clear_lvl),
    .rise_out());

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  scq_pkg::scq_mode_t mode;
  scq_pkg::scq_log_t logm;
  always_comb begin
    if (queue_control_word[scq_pkg::CTW_MODE_HI]) begin
      mode = scq_pkg::SCQ_CIRCULAR; // [RULE15]
    end else if (queue_control_word[scq_pkg::CTW_MODE_LO]) begin
      mode = scq_pkg::SCQ_WINDOW; // [RULE15]
    end else begin
      mode = scq_pkg::SCQ_STANDARD; // [RULE15]
    end
    if (queue_control_word[scq_pkg::CTW_NOTIME]) begin
      logm = scq_pkg::SCQ_NO_TIME; // [RULE16] [RULE7]
    end else if (queue_control_word[scq_pkg::CTW_EVERYTIME]) begin
      logm = scq_pkg::SCQ_EACH_TIME; // [RULE16] [RULE7]
    end else begin
      logm = scq_pkg::SCQ_LAST_TIME; // [RULE16] [RULE7]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Queue state
  // Private per-instance storage; no reset on the arrays, so contents are retained
  logic [scq_pkg::DATA_W-1:0] val_mem [scq_pkg::DEPTH]; // [RULE1] [RULE2]
  logic [scq_pkg::TIME_W-1:0] tim_mem [scq_pkg::DEPTH];
  scq_pkg::scq_state_t state_q, state_d;
  logic loading_q, loading_d;
  logic [scq_pkg::PTR_W-1:0] rd_q, rd_d, wr_q, wr_d, wipe_q, wipe_d;
  logic [scq_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [scq_pkg::TIME_W-1:0] last_q, last_d;
  logic wr_en, val_wr;
  logic [scq_pkg::PTR_W-1:0] wr_idx;
  logic [scq_pkg::DATA_W-1:0] wr_val;
  logic [scq_pkg::TIME_W-1:0] wr_tim;
  logic full, empty, take, pop;

  assign full = (cnt_q == scq_pkg::CNT_FULL); // [RULE17]
  assign empty = (cnt_q == scq_pkg::CNT_ZERO); // [RULE17]

  always_comb begin
    state_d = state_q;
    loading_d = loading_q;
    rd_d = rd_q;
    wr_d = wr_q;
    wipe_d = wipe_q;
    cnt_d = cnt_q;
    last_d = last_q;
    wr_en = 1'b0;
    val_wr = 1'b0;
    wr_idx = wr_q;
    wr_val = data_in;
    wr_tim = time_now;
    take = 1'b0;
    pop = 1'b0;
    case (state_q)
      scq_pkg::SCQ_RUN: begin
        if (clear_lvl) begin
          // Wipe takes DEPTH cycles; clear held only one cycle is enough
          state_d = scq_pkg::SCQ_WIPE; // [RULE14]
          wipe_d = scq_pkg::PTR_ZERO;
          loading_d = 1'b0;
          rd_d = scq_pkg::PTR_ZERO;
          wr_d = scq_pkg::PTR_ZERO;
          cnt_d = scq_pkg::CNT_ZERO;
          last_d = '0;
        end else if (en_lvl) begin // [RULE19]
          if (load_rise) begin
            loading_d = 1'b1; // [RULE11]
          end
          if (!load_lvl) begin
            loading_d = 1'b0;
          end
          // Unload on an edge, not a level, so one press drops one entry
          pop = unload_rise && !empty; // [RULE13] [RULE20]
          take = scan && (loading_q || load_rise) && load_lvl; // [RULE12]
          if (take && full && mode == scq_pkg::SCQ_STANDARD && !pop) begin
            take = 1'b0; // [RULE4]
          end
          if (take) begin
            wr_en = 1'b1;
            val_wr = 1'b1;
            wr_d = wr_q + scq_pkg::PTR_ONE; // [RULE12]
            if (logm != scq_pkg::SCQ_NO_TIME) begin
              last_d = time_now; // [RULE8]
            end
            if (logm != scq_pkg::SCQ_EACH_TIME) begin
              wr_tim = '0; // [RULE9] [RULE8]
            end
          end
          if (take && full && !pop) begin
            // Window drops oldest first, circular overwrites its slot
            rd_d = rd_q + scq_pkg::PTR_ONE; // [RULE5] [RULE6]
          end else if (pop) begin
            rd_d = rd_q + scq_pkg::PTR_ONE; // [RULE13]
            if (!take) begin
              cnt_d = cnt_q - scq_pkg::CNT_ONE;
            end
          end else if (take) begin
            cnt_d = cnt_q + scq_pkg::CNT_ONE;
          end
        end
      end
      scq_pkg::SCQ_WIPE: begin
        wr_en = 1'b1;
        wr_idx = wipe_q;
        wr_val = '0; // [RULE14]
        wr_tim = '0;
        wipe_d = wipe_q + scq_pkg::PTR_ONE;
        if (wipe_q == scq_pkg::PTR_LAST) begin
          state_d = scq_pkg::SCQ_RUN;
        end
      end
      default: begin
        state_d = scq_pkg::SCQ_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= scq_pkg::SCQ_RUN;
      loading_q <= 1'b0;
      rd_q <= scq_pkg::PTR_ZERO;
      wr_q <= scq_pkg::PTR_ZERO;
      wipe_q <= scq_pkg::PTR_ZERO;
      cnt_q <= scq_pkg::CNT_ZERO;
      last_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      loading_q <= loading_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      wipe_q <= wipe_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      val_mem[wr_idx] <= wr_val; // [RULE1]
      tim_mem[wr_idx] <= wr_tim; // [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host read port and outputs
  scq_pkg::scq_flags_t flags_d;
  logic [scq_pkg::CTW_W-1:0] status_d;
  logic [scq_pkg::DATA_W-1:0] rdd_d;
  logic [scq_pkg::TIME_W-1:0] rdt_d;
  logic [scq_pkg::PTR_W-1:0] abs_addr;

  always_comb begin
    abs_addr = rd_q + rd_addr; // [RULE3]
    rdd_d = rd_data;
    rdt_d = rd_time;
    if (rd_stb) begin
      rdd_d = val_mem[abs_addr]; // [RULE3]
      rdt_d = tim_mem[abs_addr]; // [RULE3]
    end
    flags_d.enable_passthrough_out = en_lvl; // [RULE19]
    flags_d.empty = (cnt_d == scq_pkg::CNT_ZERO); // [RULE17] [RULE20]
    flags_d.full = (cnt_d == scq_pkg::CNT_FULL); // [RULE17]
    flags_d.trig = (trigger_count != scq_pkg::CNT_ZERO) && (cnt_d >= trigger_count); // [RULE18]
    status_d = '0;
    status_d[scq_pkg::ST_EN] = en_lvl;
    status_d[scq_pkg::ST_LOAD] = load_lvl;
    status_d[scq_pkg::ST_UNLOAD] = unload_lvl;
    status_d[scq_pkg::ST_CLEAR] = clear_lvl;
    status_d[scq_pkg::ST_ENO] = flags_d.enable_passthrough_out;
    status_d[scq_pkg::ST_EMPTY] = flags_d.empty;
    status_d[scq_pkg::ST_TRIG] = flags_d.trig;
    status_d[scq_pkg::ST_FULL] = flags_d.full;
    status_d[scq_pkg::CTW_MODE_HI] = queue_control_word[scq_pkg::CTW_MODE_HI];
    status_d[scq_pkg::CTW_MODE_LO] = queue_control_word[scq_pkg::CTW_MODE_LO];
    status_d[scq_pkg::CTW_NOTIME] = queue_control_word[scq_pkg::CTW_NOTIME];
    status_d[scq_pkg::CTW_EVERYTIME] = queue_control_word[scq_pkg::CTW_EVERYTIME];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
      rd_time <= '0;
      last_time <= '0;
      flags <= '{enable_passthrough_out: 1'b0, empty: 1'b1, trig: 1'b0, full: 1'b0};
      queue_base_pointer <= scq_pkg::PTR_ZERO;
      fill_count <= scq_pkg::CNT_ZERO;
      status_word <= '0;
    end else if (ce) begin
      rd_data <= rdd_d;
      rd_time <= rdt_d;
      last_time <= last_d; // [RULE8]
      flags <= flags_d;
      queue_base_pointer <= rd_d;
      fill_count <= cnt_d;
      status_word <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_take_standard_full;
    state_q == scq_pkg::SCQ_RUN && !clear_lvl && en_lvl && scan && loading_q && load_lvl && !pop && full &&
      mode == scq_pkg::SCQ_STANDARD;
  endsequence
  sequence s_take_full_other;
    state_q == scq_pkg::SCQ_RUN && wr_en && !pop && full && mode != scq_pkg::SCQ_STANDARD;
  endsequence
  sequence s_store_sample;
    ce && val_wr && state_q == scq_pkg::SCQ_RUN;
  endsequence

  a_standard_refuse: assert property (@(posedge clk) disable iff (rst) // [RULE4]
    ce ##0 s_take_standard_full |=> cnt_q == $past(cnt_q) && wr_q == $past(wr_q) && last_q == $past(last_q))
    else $error("standard mode took a sample while full");
  a_overflow_keep_full: assert property (@(posedge clk) disable iff (rst) // [RULE5]
    ce ##0 s_take_full_other |=> full && rd_q == $past(rd_q) + scq_pkg::PTR_ONE)
    else $error("overflow did not drop oldest");
  a_flag_empty_full: assert property (@(posedge clk) disable iff (rst) // [RULE17]
    ##1 ce && $past(ce) |-> flags.empty == empty && flags.full == full)
    else $error("empty or full flag mismatch");
  a_disabled_frozen: assert property (@(posedge clk) disable iff (rst) // [RULE19]
    ce && !en_lvl && state_q == scq_pkg::SCQ_RUN && !clear_lvl |=> cnt_q == $past(cnt_q) && !flags.enable_passthrough_out)
    else $error("disabled block changed queue");
  a_empty_unload_noop: assert property (@(posedge clk) disable iff (rst) // [RULE20]
    ce && empty && !wr_en && state_q == scq_pkg::SCQ_RUN && !clear_lvl |=> rd_q == $past(rd_q) && empty)
    else $error("unload on empty queue moved pointer");
  a_load_advance: assert property (@(posedge clk) disable iff (rst) // [RULE12]
    ce && take |=> wr_q == $past(wr_q) + scq_pkg::PTR_ONE)
    else $error("write pointer did not advance");
  a_clear_wipes: assert property (@(posedge clk) disable iff (rst) // [RULE14]
    ce && clear_lvl && state_q == scq_pkg::SCQ_RUN |=> state_q == scq_pkg::SCQ_WIPE && cnt_q == scq_pkg::CNT_ZERO)
    else $error("clear did not start wipe");
  a_trigger_reach: assert property (@(posedge clk) disable iff (rst) // [RULE18]
    ce && trigger_count != scq_pkg::CNT_ZERO && cnt_d == trigger_count |=> flags.trig)
    else $error("trigger not raised at count");
  a_unload_pops: assert property (@(posedge clk) disable iff (rst) // [RULE13]
    ce && pop && !take |=> cnt_q == $past(cnt_q) - scq_pkg::CNT_ONE)
    else $error("unload did not remove entry");

  // Storage contents, looked at one cycle after the write lands
  a_value_stored: assert property (@(posedge clk) disable iff (rst) // [RULE12]
    s_store_sample |=> val_mem[$past(wr_idx)] == $past(data_in))
    else $error("sample value not stored");
  a_each_time_store: assert property (@(posedge clk) disable iff (rst) // [RULE10]
    s_store_sample ##0 logm == scq_pkg::SCQ_EACH_TIME |=> tim_mem[$past(wr_idx)] == $past(time_now))
    else $error("sample time not stored");
  a_time_zeroed: assert property (@(posedge clk) disable iff (rst) // [RULE9]
    s_store_sample ##0 logm != scq_pkg::SCQ_EACH_TIME |=> tim_mem[$past(wr_idx)] == '0)
    else $error("time stored without every-time option");
  a_last_time_kept: assert property (@(posedge clk) disable iff (rst) // [RULE8]
    s_store_sample ##0 logm == scq_pkg::SCQ_LAST_TIME |=> last_time == $past(time_now))
    else $error("last time not updated");
  a_oldest_overwrite: assert property (@(posedge clk) disable iff (rst) // [RULE6]
    ce ##0 s_take_full_other |-> wr_idx == rd_q)
    else $error("overflow wrote outside the oldest slot");
  a_wipe_zero: assert property (@(posedge clk) disable iff (rst) // [RULE14]
    ce && state_q == scq_pkg::SCQ_WIPE |=> val_mem[$past(wipe_q)] == '0 && tim_mem[$past(wipe_q)] == '0)
    else $error("wipe left a slot set");
  a_wipe_return: assert property (@(posedge clk) disable iff (rst) // [RULE14]
    ce && state_q == scq_pkg::SCQ_WIPE && wipe_q == scq_pkg::PTR_LAST |=> state_q == scq_pkg::SCQ_RUN)
    else $error("wipe did not end after the last slot");

  // A rise seen while disabled is lost on purpose; the pin must rise again
  a_load_arm: assert property (@(posedge clk) disable iff (rst) // [RULE11]
    ce && state_q == scq_pkg::SCQ_RUN && !clear_lvl && en_lvl && load_rise |=> loading_q)
    else $error("load rise did not arm capture");
  a_eno_follows: assert property (@(posedge clk) disable iff (rst) // [RULE19]
    ce |=> flags.enable_passthrough_out == $past(en_lvl))
    else $error("enable out does not follow enable");
  a_base_pointer: assert property (@(posedge clk) disable iff (rst) // [RULE3]
    ce |=> queue_base_pointer == rd_q)
    else $error("base pointer output out of step");
  a_read_hold: assert property (@(posedge clk) disable iff (rst) // [RULE3]
    ce && !rd_stb |=> rd_data == $past(rd_data))
    else $error("read data changed without a strobe");
endmodule
`default_nettype wire

// ---- scq_upstream.sv ----
// Upstream source model: scan-timed sample values and a running time-stamp
`timescale 1ns/1ps
`default_nettype none
module scq_upstream (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Scan strobe seen by the queue
  input wire logic scan,
  // Sample value and current time
  output logic [scq_pkg::DATA_W-1:0] data_in,
  output logic [scq_pkg::TIME_W-1:0] time_now
);
  ////////////////////////////////////////////////////////////////////////////////
  // New value after every scan, so a capture in the wrong cycle reads a stale sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_in <= 16'hA000;
      time_now <= 48'h000000001000;
    end else begin
      time_now <= time_now + 48'h000000000001;
      if (scan) begin
        data_in <= data_in + 16'h0031;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb_scq_queue.sv ----
// Self-checking bench for the scan-cycle sample queue
`timescale 1ns/1ps
`default_nettype none
module tb_scq_queue;
  logic clk;
  logic rst;
  logic ce;
  logic scan;
  logic rd_stb;
  scq_pkg::scq_ctrl_t ctrl;
  logic [15:0] cw;
  logic [4:0] trig_n;
  logic [3:0] rd_addr;
  logic [15:0] data_in;
  logic [15:0] rd_data;
  logic [15:0] status_word;
  logic [47:0] time_now;
  logic [47:0] rd_time;
  logic [47:0] last_time;
  logic [47:0] lt;
  logic [3:0] base;
  scq_pkg::scq_flags_t flags;
  logic [3:0] base_ptr;
  logic [4:0] fill_count;
  logic [1:0] mode;
  logic [1:0] logopt;
  logic [63:0] mq[$];
  int errors;
  int tests_run;

  scq_queue i_dut (.clk(clk), .rst(rst), .ce(ce), .scan(scan), .ctrl_pins(ctrl), .data_in(data_in),
    .time_now(time_now), .queue_control_word(cw), .trigger_count(trig_n), .rd_addr(rd_addr),
    .rd_stb(rd_stb), .rd_data(rd_data), .rd_time(rd_time), .last_time(last_time), .flags(flags),
    .queue_base_pointer(base_ptr), .fill_count(fill_count), .status_word(status_word));
  scq_upstream i_up (.clk(clk), .rst(rst), .scan(scan), .data_in(data_in), .time_now(time_now));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    rd_stb <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
  endtask

  // Pins pass two sync flops, so give them four edges before anything depends on them
  task automatic pins(input logic en, input logic ld, input logic ul, input logic cl);
    @(posedge clk);
    if (ul && !ctrl.unload && en && mq.size() > 0) begin
      void'(mq.pop_front());
      base++;
    end
    if (cl) begin
      mq.delete();
      base = 4'h0;
    end
    ctrl <= '{en: en, load: ld, unload: ul, clear: cl};
    repeat (4) @(posedge clk);
  endtask

  // Bits are hi, every-time, no-time, lo
  task automatic cfg(input logic [3:0] bits, input logic [4:0] tn);
    @(posedge clk);
    cw <= {4'h0, bits, 8'h00};
    trig_n <= tn;
    mode = bits[3] ? 2'h2 : {1'b0, bits[0]};
    logopt = bits[2] ? 2'h2 : {1'b0, bits[1]};
  endtask

  // One-cycle gap between scans keeps each strobe a clean pulse
  task automatic scans(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      scan <= 1'b1;
      #1;
      if (ctrl.load && ctrl.en && ce) begin
        if (mq.size() == 16 && mode != 2'h0) begin
          void'(mq.pop_front());
          base++;
        end
        if (mq.size() < 16) begin
          mq.push_back({data_in, time_now});
          lt = time_now;
        end
      end
      @(posedge clk);
      scan <= 1'b0;
    end
  endtask

  task automatic check;
    logic [63:0] e;
    logic [7:0] st;
    repeat (2) @(posedge clk);
    #1;
    st = {mq.size() == 16, trig_n != 5'h00 && mq.size() >= trig_n, mq.size() == 0, ctrl.en,
      ctrl.clear, ctrl.unload, ctrl.load, ctrl.en};
    cmp(fill_count, mq.size(), "count");
    cmp(flags.empty, mq.size() == 0, "empty");
    cmp(flags.full, mq.size() == 16, "full");
    cmp(flags.trig, trig_n != 5'h00 && mq.size() >= trig_n, "trigger");
    cmp(flags.enable_passthrough_out, ctrl.en, "enable out");
    cmp(base_ptr, base, "base pointer");
    cmp(status_word[7:0], st, "status bits");
    cmp(status_word[11:8], cw[11:8], "config echo");
    if (logopt != 2'h1 && mq.size() > 0) cmp(last_time, lt, "last time");
    for (int i = 0; i < mq.size(); i++) begin
      e = mq[i];
      rd(i[3:0]);
      cmp(rd_data, e[63:48], "data");
      cmp(rd_time, logopt == 2'h2 ? e[47:0] : 48'h000000000000, "time");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Standard mode past full, then room made by one unload
  task automatic t_basic;
    check;
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    check;
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    scans(18);
    check;
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    check;
    scans(1);
    check;
  endtask

  task automatic t_clear;
    pins(1'b1, 1'b0, 1'b0, 1'b1);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (20) @(posedge clk);
    check;
    rd(4'h3);
    cmp(rd_data, 16'h0000, "erased slot");
  endtask

  // Window, both circular encodings, every logging option, three trigger counts
  task automatic t_modes;
    logic [8:0] tbl [3] = '{9'h0B0, 9'h140, 9'h121};
    foreach (tbl[k]) begin
      t_clear;
      cfg(tbl[k][8:5], tbl[k][4:0]);
      pins(1'b1, 1'b1, 1'b0, 1'b0);
      scans(19);
      check;
    end
  endtask

  // With ce low the queue must ignore scans entirely, even with load and enable up
  task automatic t_enable;
    @(posedge clk);
    ce <= 1'b0;
    scans(2);
    @(posedge clk);
    ce <= 1'b1;
    check;
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    scans(3);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    check;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (10000) @(posedge clk);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    scan = 1'b0;
    rd_stb = 1'b0;
    rd_addr = 4'h0;
    ctrl = '0;
    cw = 16'h0000;
    trig_n = 5'h05;
    mode = 2'h0;
    logopt = 2'h0;
    lt = 48'h000000000000;
    base = 4'h0;
    errors = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_basic;
    t_clear;
    t_modes;
    t_enable;
    end_sim;
  end
endmodule
`default_nettype wire
